/* File: rtl/lcs_pkg.sv */
// package: constants for the link capability and status register bank
package lcs_pkg;

  // ---------------------------------------------------------------
  // bus and map
  // ---------------------------------------------------------------
  localparam int unsigned LCS_ADDR_W = 8;
  localparam int unsigned LCS_DATA_W = 32;
  localparam logic [LCS_ADDR_W-1:0] LCS_OFS_CAPSTAT = 8'h04;
  localparam logic [LCS_ADDR_W-1:0] LCS_OFS_CONTROL = 8'h08;
  localparam logic [LCS_ADDR_W-1:0] LCS_OFS_COUNTS = 8'h0c;
  localparam logic [LCS_DATA_W-1:0] LCS_ZERO_WORD = 32'h0000_0000;

  // ---------------------------------------------------------------
  // capability and status word fields
  // ---------------------------------------------------------------
  localparam int unsigned LCS_BIT_DISC_READY = 0;
  localparam int unsigned LCS_BIT_CREDIT_KIND = 1;
  localparam int unsigned LCS_BIT_PACKING = 2;

  // ---------------------------------------------------------------
  // own control and count words
  // ---------------------------------------------------------------
  localparam int unsigned LCS_BIT_HOLD = 0;
  localparam logic LCS_HOLD_RESET = 1'b0;
  localparam int unsigned LCS_CNT_W = 6;
  localparam int unsigned LCS_LINKS = 64;
  localparam int unsigned LCS_SUP_LSB = 0;
  localparam int unsigned LCS_ACT_LSB = 8;

  // ---------------------------------------------------------------
  // credit pool encoding
  // ---------------------------------------------------------------
  localparam logic LCS_CREDIT_PER_LINK = 1'b0;
  localparam logic LCS_CREDIT_POOLED = 1'b1;

  // ---------------------------------------------------------------
  // readiness qualification
  // ---------------------------------------------------------------
  localparam int unsigned LCS_CLK_MHZ = 40;
  localparam int unsigned LCS_SETTLE_NS = 100;
  localparam int unsigned LCS_SETTLE_CYC =
    (LCS_SETTLE_NS * LCS_CLK_MHZ + 999) / 1000 > 0 ?
    (LCS_SETTLE_NS * LCS_CLK_MHZ + 999) / 1000 : 1;
  localparam int unsigned LCS_SETTLE_W = 4;

  typedef enum logic [2:0] {
    LCS_NOT_READY = 3'b001,
    LCS_QUALIFY = 3'b010,
    LCS_READY = 3'b100
  } lcs_ready_e;

endpackage

/* File: rtl/lcs_ready_tracker.sv */
// module: discovery readiness tracker for the links of one port
module lcs_ready_tracker
  import lcs_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic links_ok,
  input wire logic hold,
  output logic ready
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  lcs_ready_e state;
  lcs_ready_e next_state;
  logic [LCS_SETTLE_W-1:0] settle;

  localparam logic [LCS_SETTLE_W-1:0] SETTLE_LAST = LCS_SETTLE_W'(LCS_SETTLE_CYC - 1);

  // readiness must hold steady before it is shown, so a glitching
  // link cannot invite credit grants it then cannot accept
  always_comb begin
    next_state = state;
    case (state)
      LCS_NOT_READY: begin
        if (links_ok && !hold) begin
          next_state = LCS_QUALIFY;
        end
      end
      LCS_QUALIFY: begin
        if (!links_ok || hold) begin
          next_state = LCS_NOT_READY;
        end else if (settle == SETTLE_LAST) begin
          next_state = LCS_READY;
        end
      end
      LCS_READY: begin
        if (!links_ok || hold) begin
          next_state = LCS_NOT_READY;
        end
      end
      default: begin
        next_state = LCS_NOT_READY;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= LCS_NOT_READY;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      settle <= '0;
    end else if (state == LCS_QUALIFY && next_state == LCS_QUALIFY) begin
      settle <= settle + 1'b1;
    end else begin
      settle <= '0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ready <= 1'b0;
    end else begin
      ready <= (next_state == LCS_READY);
    end
  end

endmodule // lcs_ready_tracker

/* File: rtl/lcs_top.sv */
// module: link capability and status register bank for one port

// ---------------------------------------------------------------
// notes
// ---------------------------------------------------------------
module lcs_top
  import lcs_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [LCS_ADDR_W-1:0] addr,
  input wire logic [LCS_DATA_W-1:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [LCS_DATA_W-1:0] rd_data,
  input wire logic [LCS_LINKS-1:0] link_config_ready,
  input wire logic [LCS_LINKS-1:0] link_grant_ready,
  input wire logic [LCS_CNT_W-1:0] supported_link_count,
  input wire logic [LCS_CNT_W-1:0] active_link_count,
  input wire logic credit_pool_strap,
  input wire logic packing_strap,
  output logic discovery_ready_flag
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // count n encodes n+1 links, so link 0 is always covered
  function automatic logic [LCS_LINKS-1:0] span_mask(input logic [LCS_CNT_W-1:0] count);
    logic [LCS_LINKS-1:0] mask;
    mask = '0;
    for (int i = 0; i < LCS_LINKS; i++) begin
      if (i <= int'(count)) begin
        mask[i] = 1'b1;
      end
    end
    return mask;
  endfunction

  function automatic logic span_all(input logic [LCS_LINKS-1:0] vec,
                                    input logic [LCS_CNT_W-1:0] count);
    logic [LCS_LINKS-1:0] mask;
    mask = span_mask(count);
    return ((vec & mask) == mask);
  endfunction

  function automatic logic hit(input logic [LCS_ADDR_W-1:0] a,
                               input logic [LCS_ADDR_W-1:0] ofs);
    return (a == ofs);
  endfunction

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  // straps are caught on the first edge after reset release, never
  // by the reset itself, and then held until the next reset
  logic strap_taken;
  logic credit_pool_kind;
  logic packing_supported;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      credit_pool_kind <= LCS_CREDIT_PER_LINK;
    end else if (!strap_taken) begin
      credit_pool_kind <= credit_pool_strap;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      packing_supported <= 1'b0;
    end else if (!strap_taken) begin
      packing_supported <= packing_strap;
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  // software may hold discovery off while it reprograms the port;
  // this is the only writable state in the bank
  logic hold_discovery;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hold_discovery <= LCS_HOLD_RESET;
    end else if (wr_strobe && hit(addr, LCS_OFS_CONTROL)) begin
      hold_discovery <= wr_data[LCS_BIT_HOLD];
    end
  end

  // ---------------------------------------------------------------
  // readiness
  // ---------------------------------------------------------------
  // one readiness verdict for every supported link; links beyond the
  // count are ignored, so a partly populated port still qualifies
  logic links_ok;
  logic tracker_ready;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      links_ok <= 1'b0;
    end else begin
      links_ok <= strap_taken &&
                  span_all(link_config_ready, supported_link_count) &&
                  span_all(link_grant_ready, supported_link_count);
    end
  end

  lcs_ready_tracker u_tracker (
    .clock(clock),
    .arst_n(arst_n),
    .links_ok(links_ok),
    .hold(hold_discovery),
    .ready(tracker_ready)
  );

  // the status part is a single value shared by all enabled links
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      discovery_ready_flag <= 1'b0;
    end else begin
      discovery_ready_flag <= tracker_ready;
    end
  end

  // ---------------------------------------------------------------
  // word assembly
  // ---------------------------------------------------------------
  logic [LCS_DATA_W-1:0] capstat_word;
  logic [LCS_DATA_W-1:0] control_word;
  logic [LCS_DATA_W-1:0] counts_word;

  always_comb begin
    capstat_word = LCS_ZERO_WORD;
    capstat_word[LCS_BIT_DISC_READY] = discovery_ready_flag;
    // zero: figures are per link; one: figures are pooled totals
    capstat_word[LCS_BIT_CREDIT_KIND] = credit_pool_kind;
    capstat_word[LCS_BIT_PACKING] = packing_supported;
  end

  always_comb begin
    control_word = LCS_ZERO_WORD;
    control_word[LCS_BIT_HOLD] = hold_discovery;
  end

  always_comb begin
    counts_word = LCS_ZERO_WORD;
    counts_word[LCS_SUP_LSB +: LCS_CNT_W] = supported_link_count;
    counts_word[LCS_ACT_LSB +: LCS_CNT_W] = active_link_count;
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // data stands only in the cycle after the strobe; unmapped offsets
  // read zero; a read changes nothing but rd_data
  logic [LCS_DATA_W-1:0] next_rd_data;

  always_comb begin
    next_rd_data = LCS_ZERO_WORD;
    if (rd_strobe) begin
      if (hit(addr, LCS_OFS_CAPSTAT)) begin
        next_rd_data = capstat_word;
      end else if (hit(addr, LCS_OFS_CONTROL)) begin
        next_rd_data = control_word;
      end else if (hit(addr, LCS_OFS_COUNTS)) begin
        next_rd_data = counts_word;
      end else begin
        next_rd_data = LCS_ZERO_WORD;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= LCS_ZERO_WORD;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // writes to the capability word and counts fall through the decode:
  // there is no storage behind them, so they cannot alter any bit

endmodule // lcs_top

/* File: sim/lcs_top_monitor.sv */
// checker: port-level assertions for the link capability and status bank
module lcs_top_monitor
  import lcs_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [LCS_ADDR_W-1:0] addr,
  input wire logic [LCS_DATA_W-1:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [LCS_DATA_W-1:0] rd_data,
  input wire logic [LCS_LINKS-1:0] link_config_ready,
  input wire logic [LCS_LINKS-1:0] link_grant_ready,
  input wire logic [LCS_CNT_W-1:0] supported_link_count,
  input wire logic [LCS_CNT_W-1:0] active_link_count,
  input wire logic credit_pool_strap,
  input wire logic packing_strap,
  input wire logic discovery_ready_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // link 0 is always supported, so its readiness gates the flag
  wire logic ok0 = link_config_ready[0] & link_grant_ready[0];
  wire logic rd_cap = rd_strobe && addr == LCS_OFS_CAPSTAT;
  wire logic rd_cnt = rd_strobe && addr == LCS_OFS_COUNTS;
  wire logic rd_map = rd_cap || rd_cnt || addr == LCS_OFS_CONTROL;
  a_read_idle_zero: assert property (!$past(rd_strobe) |-> rd_data == LCS_ZERO_WORD)
    else $error("read data not zero outside a read");
  a_cap_reserved_zero: assert property ($past(rd_cap) |-> rd_data[31:3] == 29'h0)
    else $error("capability word upper bits not zero");
  a_credit_kind_bit: assert property ($past(rd_cap) |-> rd_data[1] == credit_pool_strap)
    else $error("credit kind bit wrong");
  a_packing_bit: assert property ($past(rd_cap) |-> rd_data[2] == packing_strap)
    else $error("packing bit wrong");
  // the word is built from the flag as it stood at the read edge, one cycle back
  a_flag_in_word: assert property ($past(rd_cap) |-> rd_data[0] == $past(discovery_ready_flag))
    else $error("ready bit and flag disagree");
  a_flag_rise_gate: assert property ($rose(discovery_ready_flag) |-> $past(ok0, 4))
    else $error("flag rose without ready links");
  a_flag_fall_bound: assert property ($fell(ok0) |-> ##[1:4] !discovery_ready_flag)
    else $error("flag stayed up after link dropped");
  a_unmapped_zero: assert property ($past(rd_strobe && !rd_map) |-> rd_data == LCS_ZERO_WORD)
    else $error("unmapped read not zero");
  a_counts_word: assert property ($past(rd_cnt) |-> rd_data[5:0] == $past(supported_link_count)
    && rd_data[13:8] == $past(active_link_count))
    else $error("count word wrong");
  cover property ($rose(discovery_ready_flag));
  cover property (rd_cap ##1 rd_data[0]);
  cover property (wr_strobe && addr == LCS_OFS_CONTROL);
endmodule // lcs_top_monitor

bind lcs_top lcs_top_monitor u_mon (.clock(clock), .arst_n(arst_n), .addr(addr),
  .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
  .link_config_ready(link_config_ready), .link_grant_ready(link_grant_ready),
  .supported_link_count(supported_link_count), .active_link_count(active_link_count),
  .credit_pool_strap(credit_pool_strap), .packing_strap(packing_strap),
  .discovery_ready_flag(discovery_ready_flag));

/* File: sim/tb_top.sv */
// testbench: register and readiness checks for the link capability bank
module tb_top
  import lcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [LCS_ADDR_W-1:0] addr = 8'h00;
  logic [LCS_DATA_W-1:0] wr_data = 32'h0;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [LCS_DATA_W-1:0] rd_data;
  logic [LCS_LINKS-1:0] cfg_rdy = 64'h0;
  logic [LCS_LINKS-1:0] gnt_rdy = 64'h0;
  logic [LCS_CNT_W-1:0] sup_cnt = 6'h03;
  logic [LCS_CNT_W-1:0] act_cnt = 6'h02;
  logic credit = 1'b0;
  logic pack = 1'b1;
  logic flag;
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  lcs_top dut (.clock(clock), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .link_config_ready(cfg_rdy), .link_grant_ready(gnt_rdy),
    .supported_link_count(sup_cnt), .active_link_count(act_cnt),
    .credit_pool_strap(credit), .packing_strap(pack), .discovery_ready_flag(flag));

  initial forever #12.5 clock = ~clock;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task results();
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
  endtask
  // data stand only in the cycle after the read edge, so sample just past it
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1 check(rd_data, exp);
  endtask
  task links(input logic [63:0] c, input logic [63:0] g);
    @(posedge clock);
    cfg_rdy <= c;
    gnt_rdy <= g;
  endtask
  task wait_flag(input logic want, input int lim);
    int n;
    n = 0;
    while (flag !== want && n < lim) begin
      @(posedge clock);
      #1 n++;
    end
    check({31'h0, flag}, {31'h0, want});
  endtask
  // straps change only under reset, since they are caught once after release
  task do_reset(input logic c, input logic p);
    @(posedge clock);
    arst_n <= 1'b0;
    credit <= c;
    pack <= p;
    repeat (16) @(posedge clock);
    #1 check(rd_data, LCS_ZERO_WORD);
    check({31'h0, flag}, 32'h0);
    @(posedge clock);
    arst_n <= 1'b1;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset(1'b0, 1'b1);
    rd(LCS_OFS_CAPSTAT, 32'h4);
    rd(LCS_OFS_COUNTS, 32'h0000_0203);
    links(64'hffff_ffff_ffff_ffff, 64'h7);
    repeat (12) @(posedge clock);
    #1 check({31'h0, flag}, 32'h0);
    links(64'hffff_ffff_ffff_ffff, 64'hf);
    wait_flag(1'b1, 12);
    rd(LCS_OFS_CAPSTAT, 32'h5);
    wr(LCS_OFS_CAPSTAT, 32'hffff_ffff);
    wr(LCS_OFS_COUNTS, 32'hffff_ffff);
    wr(8'h40, 32'hffff_ffff);
    rd(LCS_OFS_CAPSTAT, 32'h5);
    rd(LCS_OFS_CAPSTAT, 32'h5);
    rd(LCS_OFS_COUNTS, 32'h0000_0203);
    rd(8'h40, LCS_ZERO_WORD);
    wr(LCS_OFS_CONTROL, 32'h1);
    rd(LCS_OFS_CONTROL, 32'h1);
    wait_flag(1'b0, 6);
    rd(LCS_OFS_CAPSTAT, 32'h4);
    wr(LCS_OFS_CONTROL, 32'h0);
    wait_flag(1'b1, 12);
    links(64'hffff_ffff_ffff_fffe, 64'hffff_ffff_ffff_ffff);
    wait_flag(1'b0, 5);
    do_reset(1'b1, 1'b0);
    rd(LCS_OFS_CAPSTAT, 32'h2);
    results();
  end
endmodule // tb_top
